// ===== design/meter_config_mode_registers.sv
// configuration and measurement-mode registers with the controls they steer
`timescale 1ns/1ps
module meter_config_mode_registers
    import meter_pkg::*;
#(
    parameter int W = 24,
    parameter logic [W-1:0] GROUND_CODE = '0,
    parameter int PEAK_W = 8,
    parameter int SRST_LEN = SRST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [15:0] addr,
    input wire logic [15:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [15:0] rdData_r,
    input wire logic [2:0][W-1:0] voltIn,
    input wire logic [2:0][W-1:0] currIn,
    input wire logic [2:0] zeroCross,
    input wire logic [PEAK_W-1:0] peakCycles,
    input wire logic thirdPulseIn,
    input wire logic fastClkIn,
    output logic integratorOn_r,
    output logic voltAdcGround_r,
    output logic currentAdcGround_r,
    output logic fastPortOn_r,
    output logic sharedPin_r,
    output logic softReset_r,
    output logic [2:0][W-1:0] voltResult_r,
    output logic [2:0][W-1:0] currResult_r,
    output logic [2:0][W-1:0] voltForCurrent_r,
    output logic [W-1:0] periodVolt_r,
    output logic [2:0] peakPhaseSelect_r,
    output logic peakWindowEnd_r
);
    // ==========================================
    // declarations
    logic [15:0] cfg_r, cfg_nxt;
    logic [7:0] mode_r, mode_nxt;
    logic [15:0] rdData_nxt;
    logic cfgHit;
    logic modeHit;
    logic srStart;
    logic srBusy;
    logic srDone;
    logic [2:0][W-1:0] vAdc;
    logic [2:0][W-1:0] iAdc;
    logic [2:0][W-1:0] voltResult_nxt;
    logic [2:0][W-1:0] currResult_nxt;
    logic sharedPin_nxt;
    logic [2:0] peakHits;
    logic [1:0] hitCount;
    logic [PEAK_W:0] peakSum;
    logic [PEAK_W-1:0] peakCnt_r, peakCnt_nxt;
    logic peakWindowEnd_nxt;

    phase_bus_if #(.W(W)) vbus ();

    // ==========================================
    // register access
    always_comb begin
        cfgHit = (addr == CFG_ADDR);
        modeHit = (addr == MODE_ADDR);
        srStart = ce && wrStrobe && cfgHit && wrData[SRST_BIT] && !srBusy && !srDone;
    end

    always_comb begin
        cfg_nxt = cfg_r;
        mode_nxt = mode_r;
        rdData_nxt = 16'h0000;
        if (ce) begin
            if (srDone) begin
                cfg_nxt = CFG_RESET;
                mode_nxt = MODE_RESET;
            end else if (wrStrobe && !srBusy) begin
                if (cfgHit) begin
                    cfg_nxt = wrData & CFG_USED_MASK;
                end
                if (modeHit) begin
                    mode_nxt = wrData[7:0] & MODE_USED_MASK;
                end
            end
            if (rdStrobe) begin
                if (cfgHit) begin
                    rdData_nxt = cfg_r;
                end else if (modeHit) begin
                    rdData_nxt = {8'h00, mode_r};
                end
            end
        end else begin
            rdData_nxt = rdData_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cfg_r <= CFG_RESET;
            mode_r <= MODE_RESET;
            rdData_r <= 16'h0000;
        end else begin
            cfg_r <= cfg_nxt;
            mode_r <= mode_nxt;
            rdData_r <= rdData_nxt;
        end
    end

    soft_reset_seq #(
        .CYCLES(SRST_LEN)
    ) u_srst (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .start(srStart),
        .busy_r(srBusy),
        .done_r(srDone)
    );

    // ==========================================
    // control outputs
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            integratorOn_r <= 1'b0;
            voltAdcGround_r <= 1'b0;
            currentAdcGround_r <= 1'b0;
            fastPortOn_r <= 1'b0;
            softReset_r <= 1'b0;
            peakPhaseSelect_r <= MODE_RESET[PEAK_LSB +: 3];
        end else if (ce) begin
            integratorOn_r <= cfg_nxt[INTEG_BIT];
            voltAdcGround_r <= cfg_nxt[VGND_BIT];
            currentAdcGround_r <= cfg_nxt[IGND_BIT];
            fastPortOn_r <= cfg_nxt[FAST_BIT];
            softReset_r <= srStart || (srBusy && !srDone);
            peakPhaseSelect_r <= mode_nxt[PEAK_LSB +: 3];
        end
    end

    // ==========================================
    // converter outputs, grounding and swap
    always_comb begin
        for (int k = 0; k < 3; k++) begin
            vAdc[k] = cfg_r[VGND_BIT] ? GROUND_CODE : voltIn[k];
            iAdc[k] = cfg_r[IGND_BIT] ? GROUND_CODE : currIn[k];
        end
        if (!ce) begin
            voltResult_nxt = voltResult_r;
            currResult_nxt = currResult_r;
        end else if (cfg_r[SWAP_BIT]) begin
            voltResult_nxt = iAdc;
            currResult_nxt = vAdc;
        end else begin
            voltResult_nxt = vAdc;
            currResult_nxt = iAdc;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            voltResult_r <= '0;
            currResult_r <= '0;
        end else begin
            voltResult_r <= voltResult_nxt;
            currResult_r <= currResult_nxt;
        end
    end

    assign vbus.volt = voltResult_r;

    // ==========================================
    // voltage routing into the power path
    for (genvar k = 0; k < 3; k++) begin : g_route
        phase_route_mux #(
            .W(W),
            .BASE(phase_t'(k))
        ) u_mux (
            .sys_clk(sys_clk),
            .reset(reset),
            .ce(ce),
            .bus(vbus.sink),
            .code(cfg_r[VFA_LSB + 2 * k +: 2]),
            .sel_r(voltForCurrent_r[k])
        );
    end

    phase_route_mux #(
        .W(W),
        .BASE(PH_A)
    ) u_period (
        .sys_clk(sys_clk),
        .reset(reset),
        .ce(ce),
        .bus(vbus.sink),
        .code(mode_r[PER_LSB +: 2]),
        .sel_r(periodVolt_r)
    );

    // ==========================================
    // shared pulse / fast clock pin
    always_comb begin
        if (!ce) begin
            sharedPin_nxt = sharedPin_r;
        end else if (cfg_r[FAST_BIT]) begin
            sharedPin_nxt = fastClkIn;
        end else begin
            sharedPin_nxt = thirdPulseIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sharedPin_r <= 1'b0;
        end else begin
            sharedPin_r <= sharedPin_nxt;
        end
    end

    // ==========================================
    // peak window: crossings on every selected phase count
    always_comb begin
        peakHits = zeroCross & mode_r[PEAK_LSB +: 3];
        hitCount = {1'b0, peakHits[0]} + {1'b0, peakHits[1]} + {1'b0, peakHits[2]};
        peakSum = {1'b0, peakCnt_r} + {{(PEAK_W - 1){1'b0}}, hitCount};
        peakCnt_nxt = peakCnt_r;
        peakWindowEnd_nxt = 1'b0;
        if (ce) begin
            if (peakCycles != '0 && peakSum >= {1'b0, peakCycles}) begin
                peakCnt_nxt = '0;
                peakWindowEnd_nxt = 1'b1;
            end else begin
                peakCnt_nxt = peakSum[PEAK_W-1:0];
            end
        end else begin
            peakWindowEnd_nxt = peakWindowEnd_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            peakCnt_r <= '0;
            peakWindowEnd_r <= 1'b0;
        end else begin
            peakCnt_r <= peakCnt_nxt;
            peakWindowEnd_r <= peakWindowEnd_nxt;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence cfgWriteSeq;
        ce && wrStrobe && cfgHit && !srBusy && !srDone;
    endsequence

    sequence srKickSeq;
        ce && wrStrobe && cfgHit && wrData[SRST_BIT] && !srBusy && !srDone;
    endsequence

    sequence srFinishSeq;
        srDone && ce;
    endsequence

    a_integ_follow: assert property (
        cfgWriteSeq |=> integratorOn_r == $past(wrData[INTEG_BIT]))
        else $error("integrator enable did not follow write");

    a_swap_path: assert property (
        ce && cfg_r[SWAP_BIT] && !cfg_r[IGND_BIT] |=> voltResult_r == $past(currIn))
        else $error("swapped voltage result lacks current data");

    a_volt_ground: assert property (
        ce && cfg_r[VGND_BIT] && !cfg_r[SWAP_BIT] |=> voltResult_r == {3{GROUND_CODE}})
        else $error("voltage channel not grounded");

    a_curr_ground: assert property (
        ce && cfg_r[IGND_BIT] && !cfg_r[SWAP_BIT] |=> currResult_r == {3{GROUND_CODE}})
        else $error("current channel not grounded");

    a_pin_fast: assert property (
        ce && cfg_r[FAST_BIT] |=> sharedPin_r == $past(fastClkIn))
        else $error("shared pin not carrying fast port clock");

    a_pin_pulse: assert property (
        ce && !cfg_r[FAST_BIT]
        |=> sharedPin_r == $past(thirdPulseIn) && fastPortOn_r == cfg_r[FAST_BIT])
        else $error("shared pin not carrying third pulse output");

    a_srst_start: assert property (
        srKickSeq |=> softReset_r && cfg_r[SRST_BIT])
        else $error("software reset did not start");

    a_srst_clear: assert property (
        srFinishSeq |=> cfg_r == CFG_RESET && mode_r == MODE_RESET && !softReset_r)
        else $error("registers not back to defaults after software reset");

    a_reserved_zero: assert property (
        (cfg_r & ~CFG_USED_MASK) == 16'h0000 && (mode_r & ~MODE_USED_MASK) == 8'h00)
        else $error("reserved bits took a value");

    a_peak_wrap: assert property (
        ce && peakCycles != '0 && peakSum >= {1'b0, peakCycles}
        |=> peakWindowEnd_r && peakCnt_r == '0)
        else $error("peak window did not close at the cycle count");

    a_read_once: assert property (
        ce && rdStrobe && modeHit |=> rdData_r == {8'h00, $past(mode_r)}
        ##1 (rdData_r == 16'h0000 || $past(rdStrobe) || !$past(ce)))
        else $error("mode read data wrong or not cleared");

    a_read_config: assert property (
        ce && rdStrobe && cfgHit
        |=> rdData_r == $past(cfg_r) && (rdData_r & ~CFG_USED_MASK) == 16'h0000)
        else $error("configuration read data wrong");

    a_read_unmapped: assert property (
        ce && rdStrobe && !cfgHit && !modeHit |=> rdData_r == 16'h0000)
        else $error("unmapped read returned data");

    a_ground_follow: assert property (
        cfgWriteSeq |=> voltAdcGround_r == $past(wrData[VGND_BIT])
        && currentAdcGround_r == $past(wrData[IGND_BIT]))
        else $error("grounding flags did not follow write");

    a_fast_follow: assert property (
        cfgWriteSeq |=> fastPortOn_r == $past(wrData[FAST_BIT]))
        else $error("fast port enable did not follow write");

    a_swap_curr: assert property (
        ce && cfg_r[SWAP_BIT] && !cfg_r[VGND_BIT] |=> currResult_r == $past(voltIn))
        else $error("swapped current result lacks voltage data");

    a_write_refused: assert property (
        ce && wrStrobe && srBusy |=> $stable(cfg_r) && $stable(mode_r))
        else $error("register changed during software reset");

    a_peak_count: assert property (
        ce && peakCycles != '0 && peakSum < {1'b0, peakCycles}
        |=> peakCnt_r == $past(peakCnt_r) + $countones($past(zeroCross & mode_r[PEAK_LSB +: 3])))
        else $error("peak count missed a selected crossing");

    a_peak_select: assert property (
        peakPhaseSelect_r == mode_r[PEAK_LSB +: 3])
        else $error("peak phase select differs from mode register");
endmodule // meter_config_mode_registers

// ===== shared/meter_pkg.sv
// constants and types shared by the configuration and mode register block
// How it works
// - configuration bit 0 turns the digital integrator on for all current inputs
// - configuration bit 3 exchanges voltage and current channel results
// - configuration bit 4 forces voltage converter outputs to their grounded value
// - configuration bit 5 forces current converter outputs to their grounded value
// - configuration bit 6 set enables fast port, its clock drives shared pin
// - configuration bit 6 clear disables fast port, third pulse drives shared pin
// - writing one to configuration bit 7 starts a software reset
// - bits 9:8 pick voltage for phase A current: A, B, C
// - bits 11:10 pick voltage for phase B current: B, C, A
// - bits 13:12 pick voltage for phase C current: C, A, B
// - routing code 11 behaves like 00, own phase voltage
// - mode bits 1:0 pick line period source phase: A, B, C
// - period source code 11 behaves like 00, phase A
// - mode bits 2, 3, 4 include phases A, B, C in peak detection
// - zero crossings of every selected phase count toward the peak cycle count
// - reserved bits of both registers have no effect
package meter_pkg;
    // ==========================================
    // register map
    localparam logic [15:0] CFG_ADDR = 16'he618;
    localparam logic [15:0] MODE_ADDR = 16'he700;
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [7:0] MODE_RESET = 8'h1c;
    localparam logic [15:0] CFG_USED_MASK = 16'h3ff9;
    localparam logic [7:0] MODE_USED_MASK = 8'h1f;
    // ==========================================
    // field positions
    localparam int INTEG_BIT = 0;
    localparam int SWAP_BIT = 3;
    localparam int VGND_BIT = 4;
    localparam int IGND_BIT = 5;
    localparam int FAST_BIT = 6;
    localparam int SRST_BIT = 7;
    localparam int VFA_LSB = 8;
    localparam int VFB_LSB = 10;
    localparam int VFC_LSB = 12;
    localparam int PER_LSB = 0;
    localparam int PEAK_LSB = 2;
    // ==========================================
    // timing
    localparam int CLK_MHZ = 40;
    localparam int SRST_TIME_NS = 500;
    localparam int SRST_CYCLES = (SRST_TIME_NS * CLK_MHZ + 999) / 1000;
    // ==========================================
    // types
    typedef enum logic [1:0] {
        PH_A = 2'b00,
        PH_B = 2'b01,
        PH_C = 2'b10
    } phase_t;
    typedef enum logic [1:0] {
        SR_IDLE = 2'b00,
        SR_HOLD = 2'b01,
        SR_DONE = 2'b10
    } srst_state_t;
endpackage

// ===== shared/phase_bus_if.sv
// three-phase voltage words handed from the register block to the routers
`timescale 1ns/1ps
interface phase_bus_if #(parameter int W = 24);
    logic [2:0][W-1:0] volt;
    modport src (output volt);
    modport sink (input volt);
endinterface

// ===== design/phase_route_mux.sv
// one-of-three phase voltage selector with reserved code folded to base phase
`timescale 1ns/1ps
module phase_route_mux
    import meter_pkg::*;
#(
    parameter int W = 24,
    parameter phase_t BASE = PH_A
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    phase_bus_if.sink bus,
    input wire logic [1:0] code,
    output logic [W-1:0] sel_r
);
    logic [1:0] step;
    logic [2:0] sum;
    logic [1:0] idx;
    logic [W-1:0] sel_nxt;

    always_comb begin
        step = (code == 2'b11) ? 2'b00 : code;
        sum = {1'b0, BASE} + {1'b0, step};
        idx = (sum >= 3'd3) ? 2'(sum - 3'd3) : sum[1:0];
        sel_nxt = ce ? bus.volt[idx] : sel_r;
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sel_r <= '0;
        end else begin
            sel_r <= sel_nxt;
        end
    end

    a_route_own: assert property (
        @(posedge sys_clk) disable iff (reset)
        ce && (code == 2'b00 || code == 2'b11) |=> sel_r == $past(bus.volt[BASE]))
        else $error("reserved or zero code did not select own phase");
    a_route_next: assert property (
        @(posedge sys_clk) disable iff (reset)
        ce && code == 2'b01 |=> sel_r == $past(bus.volt[(BASE + 1) % 3]))
        else $error("code 01 did not select the following phase");
endmodule // phase_route_mux

// ===== design/soft_reset_seq.sv
// software reset sequencer: holds busy for a fixed span, then pulses done
`timescale 1ns/1ps
module soft_reset_seq
    import meter_pkg::*;
#(
    parameter int CYCLES = SRST_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic start,
    output logic busy_r,
    output logic done_r
);
    localparam int CW = $clog2(CYCLES + 1);
    srst_state_t state_r, state_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        if (ce) begin
            unique case (state_r)
                SR_IDLE: begin
                    if (start) begin
                        state_nxt = SR_HOLD;
                        cnt_nxt = CW'(CYCLES - 1);
                    end
                end
                SR_HOLD: begin
                    if (cnt_r == '0) begin
                        state_nxt = SR_DONE;
                    end else begin
                        cnt_nxt = cnt_r - 1'b1;
                    end
                end
                SR_DONE: state_nxt = SR_IDLE;
                default: state_nxt = SR_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_r <= SR_IDLE;
            cnt_r <= '0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= (state_nxt == SR_HOLD);
            done_r <= (state_nxt == SR_DONE);
        end
    end

    a_done_single: assert property (
        @(posedge sys_clk) disable iff (reset)
        done_r && ce |=> !done_r && !busy_r)
        else $error("done lasted more than one enabled cycle");
endmodule // soft_reset_seq

// ===== test/meter_config_mode_registers_test.sv
// self-checking bench for the configuration and mode register block
`timescale 1ns/1ps
module meter_config_mode_registers_test import meter_pkg::*;;
    localparam int W = 8;
    localparam int SLEN = 4;
    logic sys_clk = 1'b0;
    logic reset, ce, wrStrobe, rdStrobe, thirdPulseIn, fastClkIn;
    logic [15:0] addr, wrData, rdData_r;
    logic [2:0][W-1:0] voltIn, currIn, voltResult_r, currResult_r, voltForCurrent_r;
    logic [W-1:0] periodVolt_r;
    logic [2:0] zeroCross, peakPhaseSelect_r;
    logic [7:0] peakCycles;
    logic integratorOn_r, voltAdcGround_r, currentAdcGround_r, fastPortOn_r, sharedPin_r;
    logic softReset_r, peakWindowEnd_r, busyM;
    logic [31:0] seed = 32'h0000_38c8;
    logic [15:0] cfgM;
    logic [7:0] modeM;
    int errors = 0, checked = 0, cycles = 0, modelCnt = 0, modelEnds = 0, seenEnds = 0;

    meter_config_mode_registers #(.W(W), .SRST_LEN(SLEN)) uut (
        .sys_clk(sys_clk), .reset(reset), .ce(ce), .addr(addr), .wrData(wrData),
        .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData_r(rdData_r),
        .voltIn(voltIn), .currIn(currIn), .zeroCross(zeroCross), .peakCycles(peakCycles),
        .thirdPulseIn(thirdPulseIn), .fastClkIn(fastClkIn),
        .integratorOn_r(integratorOn_r), .voltAdcGround_r(voltAdcGround_r),
        .currentAdcGround_r(currentAdcGround_r), .fastPortOn_r(fastPortOn_r),
        .sharedPin_r(sharedPin_r), .softReset_r(softReset_r),
        .voltResult_r(voltResult_r), .currResult_r(currResult_r),
        .voltForCurrent_r(voltForCurrent_r), .periodVolt_r(periodVolt_r),
        .peakPhaseSelect_r(peakPhaseSelect_r), .peakWindowEnd_r(peakWindowEnd_r)
    );

    // ==========================================
    // clock, timeout and peak window model
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            errors++;
            summarize();
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            modelCnt = 0;
        end else begin
            modelCnt += $countones(zeroCross & modeM[4:2]);
            if (peakCycles != 0 && modelCnt >= peakCycles) begin
                modelCnt = 0;
                modelEnds++;
            end
        end
        if (peakWindowEnd_r === 1'b1) seenEnds++;
    end

    // ==========================================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ==========================================
    // register bus master and model update
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge sys_clk);
        wrStrobe <= 1'b0;
        if (!busyM && a == CFG_ADDR) cfgM = d & 16'h3ff9;
        if (!busyM && a == MODE_ADDR) modeM = d[7:0] & 8'h1f;
        @(posedge sys_clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge sys_clk);
        rdStrobe <= 1'b0;
        #1 chk("read data", {16'h0000, exp}, {16'h0000, rdData_r});
        @(posedge sys_clk);
        #1 chk("read data idle", 32'h0000_0000, {16'h0000, rdData_r});
        @(posedge sys_clk);
    endtask

    task automatic check_outputs();
        logic [2:0][W-1:0] v, c, vr, r;
        logic [1:0] code;
        v = cfgM[VGND_BIT] ? '0 : voltIn;
        c = cfgM[IGND_BIT] ? '0 : currIn;
        vr = cfgM[SWAP_BIT] ? c : v;
        chk("volt result", vr, voltResult_r);
        chk("curr result", cfgM[SWAP_BIT] ? v : c, currResult_r);
        chk("controls", {cfgM[0], cfgM[4], cfgM[5], cfgM[6]}, {integratorOn_r,
            voltAdcGround_r, currentAdcGround_r, fastPortOn_r});
        chk("shared pin", cfgM[6] ? fastClkIn : thirdPulseIn, sharedPin_r);
        chk("peak select", modeM[4:2], peakPhaseSelect_r);
        for (int i = 0; i < 3; i++) begin
            code = cfgM[VFA_LSB + 2 * i +: 2];
            r[i] = vr[(i + (code == 2'b11 ? 0 : code)) % 3];
        end
        chk("routed volt", r, voltForCurrent_r);
        code = modeM[1:0] == 2'b11 ? 2'b00 : modeM[1:0];
        chk("period volt", vr[code], periodVolt_r);
    endtask

    // ==========================================
    // main sequence
    initial begin
        logic [31:0] d;
        logic [7:0] md;
        logic [2:0] sels [3];
        sels = '{3'b111, 3'b001, 3'b110};
        reset = 1'b1;
        ce = 1'b1;
        addr = 16'h0000;
        wrData = 16'h0000;
        wrStrobe = 1'b0;
        rdStrobe = 1'b0;
        voltIn = '0;
        currIn = '0;
        zeroCross = 3'b000;
        peakCycles = 8'h05;
        thirdPulseIn = 1'b0;
        fastClkIn = 1'b0;
        busyM = 1'b0;
        cfgM = 16'h0000;
        modeM = 8'h1c;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rd(CFG_ADDR, cfgM);
        rd(MODE_ADDR, {8'h00, modeM});
        // every routing and period code, reserved bits random
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            d[15:8] = {d[15:14], 2'(i + 2), 2'(i + 1), 2'(i)};
            d[7] = 1'b0;
            d[5:3] = (i < 4) ? 3'b000 : 3'(i - 3);
            md = d[31:24];
            md[1:0] = 2'(i + 3);
            wr(CFG_ADDR, d[15:0]);
            wr(MODE_ADDR, {8'h00, md});
            wr(16'he619, 16'(rnd()));
            rd(CFG_ADDR, cfgM);
            rd(MODE_ADDR, {8'h00, modeM});
            rd(16'he619, 16'h0000);
            voltIn <= 24'(rnd());
            currIn <= 24'(rnd());
            thirdPulseIn <= d[16];
            fastClkIn <= d[17];
            repeat (3) @(posedge sys_clk);
            #1 check_outputs();
            @(posedge sys_clk);
        end
        // clock enable low: a write is not taken
        ce <= 1'b0;
        busyM = 1'b1;
        wr(CFG_ADDR, 16'h0009);
        ce <= 1'b1;
        busyM = 1'b0;
        rd(CFG_ADDR, cfgM);
        // peak windows with one, two and three phases selected
        for (int k = 0; k < 3; k++) begin
            wr(MODE_ADDR, {8'h00, 3'b000, sels[k], 2'b00});
            repeat (2) @(posedge sys_clk);
            repeat (40) begin
                zeroCross <= 3'(rnd());
                @(posedge sys_clk);
            end
            zeroCross <= 3'b000;
            repeat (4) @(posedge sys_clk);
            chk("window ends", modelEnds, seenEnds);
        end
        // software reset, a refused write while busy, then defaults
        wr(CFG_ADDR, 16'h00c1);
        busyM = 1'b1;
        #1 chk("soft reset busy", 32'h0000_0001, {31'h0, softReset_r});
        @(posedge sys_clk);
        wr(CFG_ADDR, 16'h0001);
        rd(CFG_ADDR, 16'h00c1);
        repeat (SLEN + 4) @(posedge sys_clk);
        busyM = 1'b0;
        cfgM = 16'h0000;
        modeM = 8'h1c;
        #1 chk("soft reset done", 32'h0000_0000, {31'h0, softReset_r});
        @(posedge sys_clk);
        rd(CFG_ADDR, 16'h0000);
        rd(MODE_ADDR, 16'h001c);
        #1 check_outputs();
        summarize();
    end
endmodule // meter_config_mode_registers_test
